// ### logic/ccsf_regs.svh
// Register offsets, field positions, reset values and timing counts of the core cycle block
`ifndef CCSF_REGS_SVH
`define CCSF_REGS_SVH

// Register indices as seen by the core; APB byte address is four times the index
`define CCSF_IDX_STATUS_BANK0 10'h003
`define CCSF_IDX_STATUS_BANK1 10'h083
// Own registers, APB byte addresses
`define CCSF_ADDR_CTRL 12'h400
`define CCSF_ADDR_ACC 12'h404
`define CCSF_ADDR_PC 12'h408
`define CCSF_ADDR_PTR 12'h40c

// Data-memory file addresses inside a bank
`define CCSF_FILE_INDIRECT 7'h00
`define CCSF_FILE_STATUS 7'h03
`define CCSF_FILE_PTR 7'h04

// Status field positions
`define CCSF_ST_INDIRECT_BANK 7
`define CCSF_ST_PAGE_HIGH 6
`define CCSF_ST_PAGE_LOW 5
`define CCSF_ST_WDT_EXPIRY 4
`define CCSF_ST_SLEEP_ENTERED 3
`define CCSF_ST_NULL_RESULT 2
`define CCSF_ST_HALF_BYTE 1
`define CCSF_ST_MSB_OVF 0

// Reset values
`define CCSF_STATUS_RST 8'h18
`define CCSF_PC_RST 10'h000
`define CCSF_CTRL_RUN_RST 1'b1

// Timing: input clock cycles per instruction cycle
`define CCSF_PHASES_PER_CYCLE 4

`endif

// ### logic/ccsf_pkg.sv
// Types shared by the core cycle block
package ccsf_pkg;

    // Quadrature phase of the instruction cycle
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} ccsf_phase_t;

    // Operation classes of the instruction word
    typedef enum logic [3:0] {
        OP_NOP, OP_STORE_ACC, OP_CLEAR_REG, OP_ADD, OP_SUB, OP_AND, OP_NIBBLE_SWAP,
        OP_ROT_RIGHT, OP_ROT_LEFT, OP_BIT_CLEAR, OP_BIT_SET, OP_ADD_LIT, OP_LOAD_LIT,
        OP_JUMP, OP_WDT_CLEAR, OP_SLEEP
    } ccsf_op_t;

    // Program word: operation and argument (file, bit, literal or target)
    typedef struct packed {
        ccsf_op_t op;
        logic [9:0] arg;
    } ccsf_instr_t;

    // Arithmetic status and bank select register
    typedef struct packed {
        logic indirect_bank_select;
        logic page_select_high;
        logic page_select_low;
        logic watchdog_expiry_flag;
        logic sleep_entered_flag;
        logic null_result_flag;
        logic half_byte_flag;
        logic msb_overflow_bit;
    } ccsf_status_t;

    // Operation result with flag values and their update enables
    typedef struct packed {
        logic [7:0] result;
        logic z;
        logic dc;
        logic c;
        logic z_en;
        logic dc_en;
        logic c_en;
    } ccsf_alu_t;

endpackage

// ### logic/ccsf_phase_gen.sv
// Divide-by-four quadrature phase generator
`timescale 1ns/1ps
`default_nettype none
module ccsf_phase_gen
    import ccsf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Current phase
    output ccsf_pkg::ccsf_phase_t phase_o
);

    // Held in phase four under reset so the first cycle after release is phase one
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            phase_o <= PH_FOUR;
        else
        begin
            case (phase_o)
                PH_ONE: phase_o <= PH_TWO;
                PH_TWO: phase_o <= PH_THREE;
                PH_THREE: phase_o <= PH_FOUR;
                PH_FOUR: phase_o <= PH_ONE;
                default: phase_o <= PH_ONE;
            endcase
        end
    end

endmodule
`default_nettype wire

// ### logic/ccsf_flag_alu.sv
// Result and status flag computation for one executing instruction
`timescale 1ns/1ps
`default_nettype none
module ccsf_flag_alu
    import ccsf_pkg::*;
(
    // Operation and operands
    input wire ccsf_pkg::ccsf_op_t op_i,
    input wire logic [9:0] arg_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] opnd_i,
    input wire logic carry_i,
    // Result with flags
    output ccsf_pkg::ccsf_alu_t alu_o
);

    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic [8:0] sum;
    logic [4:0] sum_lo;
    logic [7:0] bit_mask;

    // Shared adder; subtraction adds the two's complement of the accumulator
    always_comb
    begin
        add_a = opnd_i;
        add_b = acc_i;
        add_cin = 1'b0;
        if (op_i == OP_SUB)
        begin
            add_b = ~acc_i;
            add_cin = 1'b1;
        end
        else if (op_i == OP_ADD_LIT)
            add_a = arg_i[7:0];
        sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
        sum_lo = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
        bit_mask = 8'h01 << arg_i[9:7];
    end

    // Result and flag enables per operation
    always_comb
    begin
        alu_o = '0;
        case (op_i)
            OP_STORE_ACC: alu_o.result = acc_i;
            OP_CLEAR_REG:
            begin
                alu_o.result = 8'h00;
                alu_o.z_en = 1'b1;
            end
            OP_ADD, OP_SUB, OP_ADD_LIT:
            begin
                alu_o.result = sum[7:0];
                alu_o.c = sum[8];
                alu_o.dc = sum_lo[4];
                alu_o.z_en = 1'b1;
                alu_o.dc_en = 1'b1;
                alu_o.c_en = 1'b1;
            end
            OP_AND:
            begin
                alu_o.result = opnd_i & acc_i;
                alu_o.z_en = 1'b1;
            end
            OP_NIBBLE_SWAP: alu_o.result = {opnd_i[3:0], opnd_i[7:4]};
            OP_ROT_RIGHT:
            begin
                alu_o.result = {carry_i, opnd_i[7:1]};
                alu_o.c = opnd_i[0];
                alu_o.c_en = 1'b1;
            end
            OP_ROT_LEFT:
            begin
                alu_o.result = {opnd_i[6:0], carry_i};
                alu_o.c = opnd_i[7];
                alu_o.c_en = 1'b1;
            end
            OP_BIT_CLEAR: alu_o.result = opnd_i & ~bit_mask;
            OP_BIT_SET: alu_o.result = opnd_i | bit_mask;
            OP_LOAD_LIT: alu_o.result = arg_i[7:0];
            default: alu_o.result = 8'h00;
        endcase
        alu_o.z = (alu_o.result == 8'h00);
    end

endmodule
`default_nettype wire

// ### logic/ccsf_core.sv
// Core cycle timing, two-stage pipeline and arithmetic status register
`include "ccsf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccsf_core
    import ccsf_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Program memory
    output logic [9:0] PM_ADDR_O,
    input wire ccsf_pkg::ccsf_instr_t PM_DATA_I,
    // Data memory
    output logic [8:0] DM_ADDR_O,
    output logic DM_RD_O,
    input wire logic [7:0] DM_RDATA_I,
    output logic DM_WR_O,
    output logic [7:0] DM_WDATA_O,
    // Watchdog time-out pin and core state
    input wire logic WDT_TIMEOUT_I,
    output ccsf_pkg::ccsf_phase_t PHASE_O,
    output ccsf_pkg::ccsf_status_t STATUS_O
);

    ccsf_phase_t phase;
    ccsf_status_t status_r;
    ccsf_instr_t fetch_r;
    ccsf_instr_t ir_r;
    ccsf_alu_t alu;
    logic fetch_valid_r;
    logic ir_valid_r;
    logic [9:0] pc_r;
    logic [7:0] acc_r;
    logic [7:0] ptr_r;
    logic [7:0] opnd_r;
    logic run_r;
    logic run_cycle_r;
    logic wdt_meta_r;
    logic wdt_sync_r;
    logic wdt_prev_r;
    logic wdt_event;
    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    logic [9:0] apb_idx;
    logic hit_status;
    logic hit_ctrl;
    logic hit_acc;
    logic hit_pc;
    logic hit_ptr;
    logic exec;
    logic [8:0] eff_addr;
    logic dst_status;
    logic dst_ptr;
    logic reads_file;
    logic writes_file;
    logic writes_acc;
    logic jump_now;
    logic any_flag_en;

    // Phase divider
    ccsf_phase_gen u_phase_gen (
        .clk_i(CORE_CLK_I),
        .resetn_i(RESETN_I),
        .phase_o(phase)
    );

    // Combinational result and flag values of the executing instruction
    ccsf_flag_alu u_flag_alu (
        .op_i(ir_r.op),
        .arg_i(ir_r.arg),
        .acc_i(acc_r),
        .opnd_i(opnd_r),
        .carry_i(status_r.msb_overflow_bit),
        .alu_o(alu)
    );

    assign PHASE_O = phase;
    assign STATUS_O = status_r;

    // Watchdog time-out pin synchroniser; edge taken only from the second stage
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            wdt_meta_r <= 1'b0;
            wdt_sync_r <= 1'b0;
            wdt_prev_r <= 1'b0;
        end
        else
        begin
            wdt_meta_r <= WDT_TIMEOUT_I;
            wdt_sync_r <= wdt_meta_r;
            wdt_prev_r <= wdt_sync_r;
        end
    end
    assign wdt_event = wdt_sync_r & ~wdt_prev_r;

    // APB decode; a 12-bit byte address holds every register index times four
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_access = PSEL_I & PENABLE_I & PREADY_O;
    assign apb_wr = apb_access & PWRITE_I;
    assign apb_idx = PADDR_I[11:2];
    assign hit_status = (PADDR_I[1:0] == 2'b00) &&
        ((apb_idx == `CCSF_IDX_STATUS_BANK0) || (apb_idx == `CCSF_IDX_STATUS_BANK1));
    assign hit_ctrl = (PADDR_I == `CCSF_ADDR_CTRL);
    assign hit_acc = (PADDR_I == `CCSF_ADDR_ACC);
    assign hit_pc = (PADDR_I == `CCSF_ADDR_PC);
    assign hit_ptr = (PADDR_I == `CCSF_ADDR_PTR);

    // APB answer: no wait state; every output registered from the setup cycle
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end
        else
        begin
            PREADY_O <= apb_setup;
            PSLVERR_O <= apb_setup & ~(hit_status | hit_ctrl | hit_acc | hit_pc | hit_ptr);
            PRDATA_O <= 32'h0000_0000;
            if (apb_setup && !PWRITE_I)
            begin
                if (hit_status)
                    PRDATA_O <= {24'h00_0000, status_r};
                else if (hit_ctrl)
                    PRDATA_O <= {31'h0000_0000, run_r};
                else if (hit_acc)
                    PRDATA_O <= {24'h00_0000, acc_r};
                else if (hit_pc)
                    PRDATA_O <= {22'h00_0000, pc_r};
                else if (hit_ptr)
                    PRDATA_O <= {24'h00_0000, ptr_r};
            end
        end
    end

    // Run control; sampled once per instruction so a cycle is never cut short
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            run_r <= `CCSF_CTRL_RUN_RST;
            run_cycle_r <= 1'b0;
        end
        else
        begin
            if (apb_wr && hit_ctrl)
                run_r <= PWDATA_I[0];
            if (phase == PH_FOUR)
                run_cycle_r <= run_r;
        end
    end

    // Decode of the executing instruction
    assign exec = ir_valid_r & run_cycle_r;
    assign jump_now = exec & (ir_r.op == OP_JUMP);
    always_comb
    begin
        if (ir_r.arg[6:0] == `CCSF_FILE_INDIRECT)
            eff_addr = {status_r.indirect_bank_select, ptr_r};
        else
            eff_addr = {status_r.page_select_high, status_r.page_select_low,
                ir_r.arg[6:0]};
        dst_status = (eff_addr[6:0] == `CCSF_FILE_STATUS) && !eff_addr[8];
        dst_ptr = (eff_addr[6:0] == `CCSF_FILE_PTR) && !eff_addr[8];
        reads_file = 1'b0;
        writes_file = 1'b0;
        writes_acc = 1'b0;
        case (ir_r.op)
            OP_ADD, OP_SUB, OP_AND, OP_NIBBLE_SWAP, OP_ROT_RIGHT, OP_ROT_LEFT:
            begin
                reads_file = 1'b1;
                writes_file = ir_r.arg[7];
                writes_acc = !ir_r.arg[7];
            end
            OP_BIT_CLEAR, OP_BIT_SET:
            begin
                reads_file = 1'b1;
                writes_file = 1'b1;
            end
            OP_STORE_ACC, OP_CLEAR_REG: writes_file = 1'b1;
            OP_ADD_LIT, OP_LOAD_LIT: writes_acc = 1'b1;
            default: writes_file = 1'b0;
        endcase
    end
    assign any_flag_en = alu.z_en | alu.dc_en | alu.c_en;

    // Fetch stage: count in phase one, latch word in phase four
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            pc_r <= `CCSF_PC_RST;
            PM_ADDR_O <= `CCSF_PC_RST;
            fetch_r <= '0;
            fetch_valid_r <= 1'b0;
        end
        else if (run_cycle_r)
        begin
            if (phase == PH_ONE)
            begin
                PM_ADDR_O <= pc_r;
                pc_r <= pc_r + 10'h001;
            end
            if (phase == PH_FOUR)
            begin
                fetch_r <= PM_DATA_I;
                fetch_valid_r <= !jump_now;
                if (jump_now)
                    pc_r <= ir_r.arg;
            end
        end
    end

    // Execute stage: instruction register loads in phase one while the next word is fetched
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            ir_r <= '0;
            ir_valid_r <= 1'b0;
        end
        else if (run_cycle_r && phase == PH_ONE)
        begin
            ir_r <= fetch_r;
            ir_valid_r <= fetch_valid_r;
        end
    end

    // Operand capture in phase three from internal registers or returned memory data
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
            opnd_r <= 8'h00;
        else if (exec && phase == PH_THREE)
        begin
            if (dst_status)
                opnd_r <= status_r;
            else if (dst_ptr)
                opnd_r <= ptr_r;
            else
                opnd_r <= DM_RDATA_I;
        end
    end

    // Data memory port: read strobe in phase two, write strobe in phase four
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            DM_ADDR_O <= 9'h000;
            DM_RD_O <= 1'b0;
            DM_WR_O <= 1'b0;
            DM_WDATA_O <= 8'h00;
        end
        else
        begin
            DM_RD_O <= 1'b0;
            DM_WR_O <= 1'b0;
            if (exec && phase == PH_TWO && reads_file && !dst_status && !dst_ptr)
            begin
                DM_ADDR_O <= eff_addr;
                DM_RD_O <= 1'b1;
            end
            if (exec && phase == PH_FOUR && writes_file && !dst_status && !dst_ptr)
            begin
                DM_ADDR_O <= eff_addr;
                DM_WR_O <= 1'b1;
                DM_WDATA_O <= alu.result;
            end
        end
    end

    // Accumulator and pointer destinations
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            acc_r <= 8'h00;
            ptr_r <= 8'h00;
        end
        else
        begin
            if (apb_wr && hit_ptr)
                ptr_r <= PWDATA_I[7:0];
            if (exec && phase == PH_FOUR)
            begin
                if (writes_acc)
                    acc_r <= alu.result;
                if (writes_file && dst_ptr)
                    ptr_r <= alu.result;
            end
        end
    end

    // Status register; core write in phase four overrides a bus write in the same cycle
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
            status_r <= `CCSF_STATUS_RST;
        else
        begin
            if (apb_wr && hit_status)
            begin
                // Reset-status flags are left alone
                status_r.indirect_bank_select <= PWDATA_I[`CCSF_ST_INDIRECT_BANK];
                status_r.page_select_high <= PWDATA_I[`CCSF_ST_PAGE_HIGH];
                status_r.page_select_low <= PWDATA_I[`CCSF_ST_PAGE_LOW];
                status_r.null_result_flag <= PWDATA_I[`CCSF_ST_NULL_RESULT];
                status_r.half_byte_flag <= PWDATA_I[`CCSF_ST_HALF_BYTE];
                status_r.msb_overflow_bit <= PWDATA_I[`CCSF_ST_MSB_OVF];
            end
            if (exec && phase == PH_FOUR)
            begin
                if (writes_file && dst_status)
                begin
                    status_r.indirect_bank_select <= alu.result[`CCSF_ST_INDIRECT_BANK];
                    status_r.page_select_high <= alu.result[`CCSF_ST_PAGE_HIGH];
                    status_r.page_select_low <= alu.result[`CCSF_ST_PAGE_LOW];
                    if (!any_flag_en)
                    begin
                        status_r.null_result_flag <= alu.result[`CCSF_ST_NULL_RESULT];
                        status_r.half_byte_flag <= alu.result[`CCSF_ST_HALF_BYTE];
                        status_r.msb_overflow_bit <= alu.result[`CCSF_ST_MSB_OVF];
                    end
                end
                // Flag-affecting operations win over the data write
                if (alu.z_en)
                    status_r.null_result_flag <= alu.z;
                if (alu.dc_en)
                    status_r.half_byte_flag <= alu.dc;
                if (alu.c_en)
                    status_r.msb_overflow_bit <= alu.c;
                if (ir_r.op == OP_WDT_CLEAR)
                begin
                    status_r.watchdog_expiry_flag <= 1'b1;
                    status_r.sleep_entered_flag <= 1'b1;
                end
                if (ir_r.op == OP_SLEEP)
                begin
                    status_r.watchdog_expiry_flag <= 1'b1;
                    status_r.sleep_entered_flag <= 1'b0;
                end
            end
            // A time-out beats a watchdog clear in the same cycle
            if (wdt_event)
                status_r.watchdog_expiry_flag <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### sim/ccsf_mem_model.sv
// Program and data memory model facing the core
`timescale 1ns/1ps
`default_nettype none
module ccsf_mem_model
    import ccsf_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Program memory
    input wire logic [9:0] pm_addr_i,
    output ccsf_pkg::ccsf_instr_t pm_data_o,
    // Data memory
    input wire logic [8:0] dm_addr_i,
    input wire logic dm_rd_i,
    output logic [7:0] dm_rdata_o,
    input wire logic dm_wr_i,
    input wire logic [7:0] dm_wdata_i
);
    ccsf_instr_t rom [16];
    logic [7:0] ram [512];
    logic [7:0] junk_r = 8'ha5;
    // Program word follows the address at once
    assign pm_data_o = rom[pm_addr_i[3:0]];
    // Data valid only while strobed; pattern otherwise so late sampling shows
    assign dm_rdata_o = dm_rd_i ? ram[dm_addr_i] : junk_r;
    // Write lands at the strobed edge; bench preloads ram too
    always @(posedge clk_i)
    begin
        junk_r <= ~junk_r;
        if (dm_wr_i)
        begin
            ram[dm_addr_i] <= dm_wdata_i;
        end
    end
endmodule
`default_nettype wire

// ### sim/ccsf_core_properties.sv
// Timing and status checks on the core pins
`timescale 1ns/1ps
`default_nettype none
module ccsf_core_properties
    import ccsf_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // Watched pins
    input wire logic [9:0] PM_ADDR_O,
    input wire logic [8:0] DM_ADDR_O,
    input wire logic DM_RD_O,
    input wire logic DM_WR_O,
    input wire logic WDT_TIMEOUT_I,
    input wire ccsf_pkg::ccsf_phase_t PHASE_O,
    input wire ccsf_pkg::ccsf_status_t STATUS_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // Phase steps by one every clock
    property p_phase_step;
        1 |=> 2'(PHASE_O) == 2'($past(PHASE_O)) + 2'd1;
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase skipped");
    // Program address moves only at the end of phase one
    property p_pc_hold;
        PM_ADDR_O != $past(PM_ADDR_O) |-> $past(PHASE_O) == PH_ONE;
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved late");
    // Read strobe one cycle, in phase three
    property p_rd_phase;
        DM_RD_O |-> PHASE_O == PH_THREE ##1 !DM_RD_O;
    endproperty
    a_rd_phase: assert property (p_rd_phase) else $error("read mistimed");
    // Write strobe one cycle, in phase one, never with a read
    property p_wr_phase;
        DM_WR_O |-> PHASE_O == PH_ONE && !DM_RD_O ##1 !DM_WR_O;
    endproperty
    a_wr_phase: assert property (p_wr_phase) else $error("write mistimed");
    // Read-modify-write keeps the file address
    property p_rmw_addr;
        DM_WR_O && $past(DM_RD_O, 2) |-> DM_ADDR_O == $past(DM_ADDR_O, 2);
    endproperty
    a_rmw_addr: assert property (p_rmw_addr) else $error("rmw address");
    // Status never leaks out to memory
    property p_no_status_mem;
        (DM_RD_O || DM_WR_O) && !DM_ADDR_O[8] |-> DM_ADDR_O[6:0] != 7'h03;
    endproperty
    a_no_status_mem: assert property (p_no_status_mem) else $error("status hit ram");
    // Expiry flag falls only after a time-out on the pin
    property p_wdt_fall;
        $fell(STATUS_O.watchdog_expiry_flag) |-> $past(WDT_TIMEOUT_I, 3);
    endproperty
    a_wdt_fall: assert property (p_wdt_fall) else $error("expiry fell alone");
    // Values seen while reset was held
    property p_reset_val;
        RESETN_I && !$past(RESETN_I) |-> STATUS_O[5:3] == 3'b011 && PHASE_O == PH_FOUR;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("reset values");
endmodule
bind ccsf_core ccsf_core_properties u_ccsf_core_properties (.CORE_CLK_I(CORE_CLK_I),
    .RESETN_I(RESETN_I), .PM_ADDR_O(PM_ADDR_O), .DM_ADDR_O(DM_ADDR_O), .DM_RD_O(DM_RD_O),
    .DM_WR_O(DM_WR_O), .WDT_TIMEOUT_I(WDT_TIMEOUT_I), .PHASE_O(PHASE_O), .STATUS_O(STATUS_O));
`default_nettype wire

// ### sim/tb_ccsf_core.sv
// Self-checking bench for the core cycle block
`timescale 1ns/1ps
`default_nettype none
module tb_ccsf_core;
    import ccsf_pkg::*;
    typedef struct packed {logic [13:0] w; logic [7:0] a; logic [7:0] v; logic [7:0] x;} ccsf_row_t;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, wdt = 0, pready, pslverr, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [9:0] pm_addr;
    ccsf_instr_t pm_data;
    logic [8:0] dm_addr;
    logic dm_rd, dm_wr;
    logic [7:0] dm_rdata, dm_wdata;
    ccsf_phase_t phase;
    ccsf_status_t status;
    int fail_count = 0, checks = 0;
    // Program word, file, preload, expected file value; bank bits stay clear
    ccsf_row_t rows [14] = '{'{{OP_LOAD_LIT, 10'h0ff}, 8'h0, 8'h0, 8'h0},
        '{{OP_ADD_LIT, 10'h001}, 8'h0, 8'h0, 8'h0}, '{{OP_STORE_ACC, 10'h0a0}, 8'h20, 8'h55, 8'h00},
        '{{OP_LOAD_LIT, 10'h00f}, 8'h0, 8'h0, 8'h0}, '{{OP_ADD, 10'h0a1}, 8'h21, 8'h01, 8'h10},
        '{{OP_SUB, 10'h022}, 8'h22, 8'h05, 8'h05}, '{{OP_ROT_LEFT, 10'h0a3}, 8'h23, 8'h81, 8'h02},
        '{{OP_ROT_RIGHT, 10'h0a4}, 8'h24, 8'h02, 8'h81}, '{{OP_JUMP, 10'h00a}, 8'h0, 8'h0, 8'h0},
        '{{OP_LOAD_LIT, 10'h077}, 8'h0, 8'h0, 8'h0}, '{{OP_CLEAR_REG, 10'h083}, 8'h0, 8'h0, 8'h0},
        '{{OP_WDT_CLEAR, 10'h000}, 8'h0, 8'h0, 8'h0}, '{{OP_SLEEP, 10'h000}, 8'h0, 8'h0, 8'h0},
        '{{OP_JUMP, 10'h00d}, 8'h0, 8'h0, 8'h0}};
    // Clock of 100 ns period
    always #50 clk = ~clk;
    ccsf_core u_ccsf_core (.CORE_CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PM_ADDR_O(pm_addr),
        .PM_DATA_I(pm_data), .DM_ADDR_O(dm_addr), .DM_RD_O(dm_rd), .DM_RDATA_I(dm_rdata),
        .DM_WR_O(dm_wr), .DM_WDATA_O(dm_wdata), .WDT_TIMEOUT_I(wdt), .PHASE_O(phase),
        .STATUS_O(status));
    ccsf_mem_model u_ccsf_mem_model (.clk_i(clk), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
        .dm_addr_i(dm_addr), .dm_rd_i(dm_rd), .dm_rdata_o(dm_rdata), .dm_wr_i(dm_wr),
        .dm_wdata_i(dm_wdata));
    // Count and report one comparison
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never sees pready
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, far beyond the program and bus traffic
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        for (int k = 0; k < 14; k++)
        begin
            u_ccsf_mem_model.rom[k] = rows[k].w;
            u_ccsf_mem_model.ram[rows[k].a] = rows[k].v;
        end
        // Words past the loop; the first is fetched and flushed by every loop jump
        u_ccsf_mem_model.rom[14] = '{OP_WDT_CLEAR, 10'h000};
        u_ccsf_mem_model.rom[15] = '{OP_JUMP, 10'h00f};
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        while (pm_addr !== 10'd13) @(posedge clk);
        repeat (16) @(posedge clk);
        for (int k = 0; k < 14; k++)
            if (rows[k].a != 8'h0) chk("file", rows[k].x, u_ccsf_mem_model.ram[rows[k].a]);
        chk("status", 8'h14, status);
        apb(1'b0, 12'h404, 32'h0);
        chk("acc", 32'hf6, q);
        // Time-out pulse held past the synchroniser
        wdt <= 1'b1;
        repeat (8) @(posedge clk);
        wdt <= 1'b0;
        repeat (8) @(posedge clk);
        chk("timeout", 8'h04, status);
        apb(1'b1, 12'h00c, 32'h3f);
        apb(1'b0, 12'h20c, 32'h0);
        chk("status_hi", 32'h27, q);
        apb(1'b1, 12'h20c, 32'h01);
        apb(1'b0, 12'h00c, 32'h0);
        chk("status_lo", 32'h01, q);
        // Loop word becomes a bit clear on status, then the watchdog clear runs
        u_ccsf_mem_model.rom[13] <= '{OP_BIT_CLEAR, 10'h003};
        repeat (40) @(posedge clk);
        chk("wdt_clear", 8'h18, status);
        apb(1'b1, 12'h404, 32'h55);
        apb(1'b0, 12'h404, 32'h0);
        chk("acc_ro", 32'hf6, q);
        apb(1'b0, 12'h100, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        chk("err_data", 32'h0, q);
        apb(1'b0, 12'h400, 32'h0);
        chk("run", 32'h1, q);
        // Page and arithmetic bits set so the reset has something to clear
        apb(1'b1, 12'h00c, 32'h27);
        // Second reset in mid-run
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rst_status", 8'h18, status);
        chk("rst_phase", PH_FOUR, phase);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("rel_phase", PH_THREE, phase);
        wrap_up();
    end
endmodule
`default_nettype wire
